// [src/crf_pkg.sv]
// Constants and types shared by the receive-mode message FIFO block.
package crf_pkg;

  // ----------------------------------------------------------------------
  // Widths.
  // ----------------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PTR_W     = 6;
  localparam int MAX_DEPTH = 48;
  localparam int NUM_BYTES = 8;
  localparam int ID_W      = 29;
  localparam int STD_ID_W  = 11;
  localparam int HALF_W    = 16;
  localparam int IDH_ID_W  = 13;
  localparam int DLC_W     = 4;
  localparam int LABEL_W   = 12;
  localparam int TS_W      = 16;
  localparam int DEPTH_W   = 3;
  localparam int THR_W     = 3;
  localparam int MODE_W    = 2;
  localparam int KEY_W     = 8;
  localparam int LVL_W     = 10;
  localparam int EIGHTHS   = 3;

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CFG_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PTR_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ID_LOW   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ID_HIGH  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TSTAMP   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DLC_LBL  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_DATA0    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_DATA1    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DATA2    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_DATA3    = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_WIN_CTRL = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_GCFG_LOW = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_CONTROL_REG    = 8'h38;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_IE_BIT    = 1;
  localparam int CFG_IM_BIT    = 2;
  localparam int CFG_DEPTH_LSB = 8;
  localparam int CFG_THR_LSB   = 13;
  localparam int CFGH_MODE_LSB = 0;
  localparam int ST_EMPTY_BIT  = 0;
  localparam int ST_FULL_BIT   = 1;
  localparam int ST_LOST_BIT   = 2;
  localparam int ST_IRQ_BIT    = 3;
  localparam int ST_CNT_LSB    = 8;
  localparam int WIN_SEL_BIT   = 0;
  localparam int GCFG_DCE_BIT  = 0;
  localparam int GCFG_DRE_BIT  = 1;
  localparam int GCTL_MSG_LOST_IRQ_ENABLE_BIT = 0;
  localparam int DLCL_DLC_LSB  = 12;

  // ----------------------------------------------------------------------
  // Codes.
  // ----------------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RX     = 2'h0;
  localparam logic [KEY_W-1:0]  PTR_ADV_KEY = 8'hff;
  localparam logic              HIST_FIXED  = 1'b0;

  // One stored message.
  typedef struct packed {
    logic [NUM_BYTES*8-1:0] data;
    logic [TS_W-1:0]        tstamp;
    logic [LABEL_W-1:0]     label;
    logic [DLC_W-1:0]       dlc;
    logic                   rtr;
    logic                   ide;
    logic [ID_W-1:0]        id;
  } crf_entry_type;

  // Number of message slots for each depth code.
  function automatic logic [PTR_W-1:0] crf_depth_of(input logic [DEPTH_W-1:0] code);
    case (code)
      3'h0:    crf_depth_of = 6'h00;
      3'h1:    crf_depth_of = 6'h04;
      3'h2:    crf_depth_of = 6'h08;
      3'h3:    crf_depth_of = 6'h10;
      3'h4:    crf_depth_of = 6'h20;
      default: crf_depth_of = 6'h30;
    endcase
  endfunction : crf_depth_of

endpackage : crf_pkg

// [src/crf_store_if.sv]
// Interface between the FIFO controller and its message storage.
`timescale 1ns/10ps
`default_nettype none
interface crf_store_if;
  import crf_pkg::*;
  logic                wr_en;
  logic [PTR_W-1:0]    wr_addr;
  crf_entry_type       wr_data;
  logic [PTR_W-1:0]    rd_addr;
  crf_entry_type       rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : crf_store_if
`default_nettype wire

// [src/crf_msg_store.sv]
// Message storage array of the shared FIFO, one slot per message.
`timescale 1ns/10ps
`default_nettype none
module crf_msg_store (
  input wire logic   pclk,
  crf_store_if.store st
);
  import crf_pkg::*;

  // ----------------------------------------------------------------------
  // Storage slots.
  // ----------------------------------------------------------------------
  // Slots hold data only, so they carry no reset; the counter guards them.
  crf_entry_type mem [MAX_DEPTH];

  // Each slot loads when the write pointer names it.
  for (genvar i = 0; i < MAX_DEPTH; i++) begin : g_slot
    always_ff @(posedge pclk) begin
      if (st.wr_en && (st.wr_addr == PTR_W'(i))) begin
        mem[i] <= st.wr_data;
      end
    end
  end

  // The head slot is shown without delay so the read registers track it.
  assign st.rd_data = mem[st.rd_addr];

endmodule : crf_msg_store
`default_nettype wire

// [src/crf_rx_fifo.sv]
// Shared message FIFO of one CAN channel, receive mode, with APB registers.
`timescale 1ns/10ps
`default_nettype none
module crf_rx_fifo (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [crf_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [crf_pkg::DATA_W-1:0]     pwdata,
  output logic      [crf_pkg::DATA_W-1:0]     prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           rx_valid,
  input  wire logic [crf_pkg::ID_W-1:0]       rx_identifier,
  input  wire logic                           rx_ide,
  input  wire logic                           rx_rtr,
  input  wire logic [crf_pkg::DLC_W-1:0]      rx_dlc,
  input  wire logic [crf_pkg::DLC_W-1:0]      rule_dlc_value,
  input  wire logic [crf_pkg::LABEL_W-1:0]    rule_label_value,
  input  wire logic [crf_pkg::TS_W-1:0]       rx_timestamp,
  input  wire logic [crf_pkg::NUM_BYTES*8-1:0] rx_data,
  output logic                                rx_stored,
  output logic                                rx_lost,
  output logic                                fifo_rx_irq,
  output logic                                global_err_irq
);
  import crf_pkg::*;

  // ----------------------------------------------------------------------
  // Configuration and state registers.
  // ----------------------------------------------------------------------
  logic                     fifo_enable_bit_ff;
  logic                     rx_irq_enable_bit_ff;
  logic                     irq_mode_select_ff;
  logic [DEPTH_W-1:0]       fifo_depth_sel_ff;
  logic [THR_W-1:0]         irq_threshold_sel_ff;
  logic [MODE_W-1:0]        fifo_direction_mode_ff;
  logic                     ram_window_select_ff;
  logic                     dlc_check_enable_ff;
  logic                     dlc_replace_enable_ff;
  logic                     msg_lost_irq_enable_ff;
  logic [PTR_W-1:0]         msg_count_ff;
  logic [PTR_W-1:0]         wr_ptr_ff;
  logic [PTR_W-1:0]         rd_ptr_ff;
  logic                     rx_irq_request_flag_ff;
  logic                     msg_lost_flag_ff;
  logic [DATA_W-1:0]        rdata_ff;

  logic [PTR_W-1:0]         nxt_msg_count;
  logic [PTR_W-1:0]         nxt_wr_ptr;
  logic [PTR_W-1:0]         nxt_rd_ptr;
  logic                     nxt_rx_irq_request_flag;
  logic                     nxt_msg_lost_flag;
  logic [DATA_W-1:0]        nxt_rdata;

  crf_store_if store_bus ();

  // ----------------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_wr    = psel && penable && pwrite;

  wire sel_cfg_low  = (paddr == OFF_CFG_LOW);
  wire sel_cfg_high = (paddr == OFF_CFG_HIGH);
  wire sel_status   = (paddr == OFF_STATUS);
  wire sel_ptr_ctrl = (paddr == OFF_PTR_CTRL);
  wire sel_id_low   = (paddr == OFF_ID_LOW);
  wire sel_id_high  = (paddr == OFF_ID_HIGH);
  wire sel_tstamp   = (paddr == OFF_TSTAMP);
  wire sel_dlc_lbl  = (paddr == OFF_DLC_LBL);
  wire sel_data0    = (paddr == OFF_DATA0);
  wire sel_data1    = (paddr == OFF_DATA1);
  wire sel_data2    = (paddr == OFF_DATA2);
  wire sel_data3    = (paddr == OFF_DATA3);
  wire sel_win_ctrl = (paddr == OFF_WIN_CTRL);
  wire sel_gcfg_low = (paddr == OFF_GCFG_LOW);
  wire sel_global_control_reg    = (paddr == OFF_GLOBAL_CONTROL_REG);

  wire sel_hit = sel_cfg_low | sel_cfg_high | sel_status | sel_ptr_ctrl
               | sel_id_low | sel_id_high | sel_tstamp | sel_dlc_lbl
               | sel_data0 | sel_data1 | sel_data2 | sel_data3
               | sel_win_ctrl | sel_gcfg_low | sel_global_control_reg;

  // The slave never inserts wait states; unmapped offsets answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !sel_hit;
  assign prdata  = rdata_ff;

  // ----------------------------------------------------------------------
  // FIFO status and transfer conditions.
  // ----------------------------------------------------------------------
  // The queue works for reception only in receive mode; transmit mode is
  // not built here, so any other mode simply keeps the receive path idle.
  wire              rx_mode   = (fifo_direction_mode_ff == MODE_RX);
  wire [PTR_W-1:0]  depth     = crf_depth_of(fifo_depth_sel_ff);
  wire              fifo_live = fifo_enable_bit_ff && rx_mode && (depth != '0);

  wire fifo_full_flag  = (depth != '0) && (msg_count_ff == depth);
  wire fifo_empty_flag = (msg_count_ff == '0);

  // A message with nowhere to go is reported as lost, never overwritten.
  wire do_store = rx_valid && fifo_live && !fifo_full_flag;
  wire do_lose  = rx_valid && fifo_live && fifo_full_flag;

  // Advance is ignored while disabled or empty so the counter never wraps.
  wire pointer_advance_field_hit = (pwdata[KEY_W-1:0] == PTR_ADV_KEY);
  wire do_advance = apb_wr && sel_ptr_ctrl && pointer_advance_field_hit
                  && fifo_enable_bit_ff && !fifo_empty_flag;

  assign rx_stored = do_store;
  assign rx_lost   = do_lose;

  // ----------------------------------------------------------------------
  // Counter and pointers.
  // ----------------------------------------------------------------------
  wire [PTR_W-1:0] depth_last = depth - 1'b1;
  wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr_ff == depth_last) ? '0 : wr_ptr_ff + 1'b1;
  wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr_ff == depth_last) ? '0 : rd_ptr_ff + 1'b1;
  wire [PTR_W-1:0] count_inc  = msg_count_ff + 1'b1;
  wire [PTR_W-1:0] count_dec  = msg_count_ff - 1'b1;

  // A store and an advance in the same cycle leave the count unchanged.
  // Disabling the FIFO drops its contents, but not its interrupt flag.
  assign nxt_msg_count = !fifo_enable_bit_ff       ? '0 :
                         (do_store && !do_advance) ? count_inc :
                         (do_advance && !do_store) ? count_dec :
                         msg_count_ff;
  assign nxt_wr_ptr    = !fifo_enable_bit_ff ? '0 :
                         do_store            ? wr_ptr_inc :
                         wr_ptr_ff;
  assign nxt_rd_ptr    = !fifo_enable_bit_ff ? '0 :
                         do_advance          ? rd_ptr_inc :
                         rd_ptr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_count_ff <= '0;
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
    end else begin
      msg_count_ff <= nxt_msg_count;
      wr_ptr_ff    <= nxt_wr_ptr;
      rd_ptr_ff    <= nxt_rd_ptr;
    end
  end

  // ----------------------------------------------------------------------
  // Message capture.
  // ----------------------------------------------------------------------
  // The label, and the DLC when DLC check and replace are both set, are taken from the accepting rule at store time, so
  // later changes to the global configuration do not rewrite old messages.
  wire dlc_swap = dlc_check_enable_ff && dlc_replace_enable_ff;

  crf_entry_type rx_entry;
  assign rx_entry.data   = rx_data;
  assign rx_entry.tstamp = rx_timestamp;
  assign rx_entry.label  = rule_label_value;
  assign rx_entry.dlc    = dlc_swap ? rule_dlc_value : rx_dlc;
  assign rx_entry.rtr    = rx_rtr;
  assign rx_entry.ide    = rx_ide;
  assign rx_entry.id     = rx_identifier;

  assign store_bus.wr_en   = do_store;
  assign store_bus.wr_addr = wr_ptr_ff;
  assign store_bus.wr_data = rx_entry;
  assign store_bus.rd_addr = rd_ptr_ff;

  crf_msg_store u_store (
    .pclk (pclk),
    .st   (store_bus.store)
  );

  // ----------------------------------------------------------------------
  // Receive interrupt request.
  // ----------------------------------------------------------------------
  // Level in messages for the chosen eighth: depth * (code + 1) / 8.
  // With depth four the even codes truncate; software must avoid them.
  wire [LVL_W-1:0] thr_prod  = LVL_W'(depth) * (LVL_W'(irq_threshold_sel_ff) + LVL_W'(1));
  wire [LVL_W-1:0] thr_level = thr_prod >> EIGHTHS;
  wire             thr_hit   = (LVL_W'(count_inc) == thr_level);

  wire rx_event = do_store && (irq_mode_select_ff || thr_hit);

  // Write zero clears a flag; a new event in the same cycle still sets it.
  wire clr_irq  = apb_wr && sel_status && !pwdata[ST_IRQ_BIT];
  wire clr_lost = apb_wr && sel_status && !pwdata[ST_LOST_BIT];

  // The flag ignores the enable bit on purpose: it stays until cleared.
  assign nxt_rx_irq_request_flag = rx_event ||
                                   (rx_irq_request_flag_ff && !clr_irq);
  assign nxt_msg_lost_flag       = do_lose ||
                                   (msg_lost_flag_ff && !clr_lost);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_request_flag_ff <= 1'b0;
      msg_lost_flag_ff       <= 1'b0;
    end else begin
      rx_irq_request_flag_ff <= nxt_rx_irq_request_flag;
      msg_lost_flag_ff       <= nxt_msg_lost_flag;
    end
  end

  assign fifo_rx_irq    = rx_irq_request_flag_ff && rx_irq_enable_bit_ff;
  assign global_err_irq = msg_lost_flag_ff && msg_lost_irq_enable_ff;

  // ----------------------------------------------------------------------
  // Configuration writes.
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_enable_bit_ff   <= 1'b0;
      rx_irq_enable_bit_ff <= 1'b0;
      irq_mode_select_ff   <= 1'b0;
      fifo_depth_sel_ff    <= '0;
      irq_threshold_sel_ff <= '0;
    end else if (apb_wr && sel_cfg_low) begin
      fifo_enable_bit_ff   <= pwdata[CFG_EN_BIT];
      rx_irq_enable_bit_ff <= pwdata[CFG_IE_BIT];
      irq_mode_select_ff   <= pwdata[CFG_IM_BIT];
      fifo_depth_sel_ff    <= pwdata[CFG_DEPTH_LSB +: DEPTH_W];
      irq_threshold_sel_ff <= pwdata[CFG_THR_LSB +: THR_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_direction_mode_ff <= MODE_RX;
    end else if (apb_wr && sel_cfg_high) begin
      fifo_direction_mode_ff <= pwdata[CFGH_MODE_LSB +: MODE_W];
    end
  end

  // Global bits that this FIFO listens to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_window_select_ff   <= 1'b0;
      dlc_check_enable_ff    <= 1'b0;
      dlc_replace_enable_ff  <= 1'b0;
      msg_lost_irq_enable_ff <= 1'b0;
    end else begin
      if (apb_wr && sel_win_ctrl) begin
        ram_window_select_ff <= pwdata[WIN_SEL_BIT];
      end
      if (apb_wr && sel_gcfg_low) begin
        dlc_check_enable_ff   <= pwdata[GCFG_DCE_BIT];
        dlc_replace_enable_ff <= pwdata[GCFG_DRE_BIT];
      end
      if (apb_wr && sel_global_control_reg) begin
        msg_lost_irq_enable_ff <= pwdata[GCTL_MSG_LOST_IRQ_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Head message views.
  // ----------------------------------------------------------------------
  crf_entry_type head;
  assign head = store_bus.rd_data;

  // Window open only in receive mode with RAM window 1 chosen.
  wire msg_window = rx_mode && ram_window_select_ff;

  // Standard identifiers hide the upper ID bits.
  wire [HALF_W-1:0]   id_low_std = {{(HALF_W-STD_ID_W){1'b0}}, head.id[STD_ID_W-1:0]};
  wire [HALF_W-1:0]   id_low_val = head.ide ? head.id[HALF_W-1:0] : id_low_std;
  wire [IDH_ID_W-1:0] id_high_id = head.ide ? head.id[ID_W-1:HALF_W] : '0;
  // The history store bit has no meaning in receive mode and reads fixed.
  wire [HALF_W-1:0]   id_high_val = {head.ide, head.rtr, HIST_FIXED, id_high_id};

  // Bytes past the stored length read as zero, one mask per byte.
  logic [NUM_BYTES*8-1:0] data_vis;
  for (genvar b = 0; b < NUM_BYTES; b++) begin : g_byte
    wire byte_on = (DLC_W'(b) < head.dlc);
    assign data_vis[b*8 +: 8] = byte_on ? head.data[b*8 +: 8] : 8'h00;
  end

  wire [HALF_W-1:0] dlc_lbl_val = {head.dlc, head.label};

  // ----------------------------------------------------------------------
  // Read data selection.
  // ----------------------------------------------------------------------
  wire [DATA_W-1:0] rd_cfg_low =
    (DATA_W'(fifo_enable_bit_ff)   << CFG_EN_BIT)    |
    (DATA_W'(rx_irq_enable_bit_ff) << CFG_IE_BIT)    |
    (DATA_W'(irq_mode_select_ff)   << CFG_IM_BIT)    |
    (DATA_W'(fifo_depth_sel_ff)    << CFG_DEPTH_LSB) |
    (DATA_W'(irq_threshold_sel_ff) << CFG_THR_LSB);

  wire [DATA_W-1:0] rd_status =
    (DATA_W'(fifo_empty_flag)        << ST_EMPTY_BIT) |
    (DATA_W'(fifo_full_flag)         << ST_FULL_BIT)  |
    (DATA_W'(msg_lost_flag_ff)       << ST_LOST_BIT)  |
    (DATA_W'(rx_irq_request_flag_ff) << ST_IRQ_BIT)   |
    (DATA_W'(msg_count_ff)           << ST_CNT_LSB);

  wire [DATA_W-1:0] rd_global =
    sel_win_ctrl ? (DATA_W'(ram_window_select_ff) << WIN_SEL_BIT) :
    sel_gcfg_low ? ((DATA_W'(dlc_check_enable_ff) << GCFG_DCE_BIT) |
                    (DATA_W'(dlc_replace_enable_ff) << GCFG_DRE_BIT)) :
    sel_global_control_reg    ? (DATA_W'(msg_lost_irq_enable_ff) << GCTL_MSG_LOST_IRQ_ENABLE_BIT) :
    '0;

  // Message registers read zero while the window is closed.
  wire [HALF_W-1:0] rd_msg =
    sel_id_low  ? id_low_val :
    sel_id_high ? id_high_val :
    sel_tstamp  ? head.tstamp :
    sel_dlc_lbl ? dlc_lbl_val :
    sel_data0   ? data_vis[0*HALF_W +: HALF_W] :
    sel_data1   ? data_vis[1*HALF_W +: HALF_W] :
    sel_data2   ? data_vis[2*HALF_W +: HALF_W] :
    sel_data3   ? data_vis[3*HALF_W +: HALF_W] :
    '0;

  wire [DATA_W-1:0] rd_msg_word = msg_window ? DATA_W'(rd_msg) : '0;

  wire [DATA_W-1:0] rd_mux =
    sel_cfg_low  ? rd_cfg_low :
    sel_cfg_high ? (DATA_W'(fifo_direction_mode_ff) << CFGH_MODE_LSB) :
    sel_status   ? rd_status :
    rd_global | rd_msg_word;

  // Read data is caught in the setup cycle so prdata comes from a flop.
  // The trade-off: an event in that same cycle shows on the next read.
  assign nxt_rdata = apb_setup && !pwrite ? rd_mux : rdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule : crf_rx_fifo
`default_nettype wire

// [verif/crf_rx_src.sv]
// Stand-in for the receive path that offers filtered messages to the FIFO.
`timescale 1ns/10ps
`default_nettype none
module crf_rx_src (
  input  wire logic           pclk,
  output logic                rx_valid,
  output var crf_pkg::crf_entry_type msg,
  output logic [3:0]          rule_dlc
);
  import crf_pkg::*;
  initial begin
    rx_valid = 1'b0;
    msg      = '0;
    rule_dlc = 4'h0;
  end
  // One message for one cycle; the fields then invert, so stale values never pass as good.
  task automatic send(input crf_entry_type m, input logic [3:0] rd);
    @(posedge pclk);
    rx_valid <= 1'b1;
    msg      <= m;
    rule_dlc <= rd;
    @(posedge pclk);
    rx_valid <= 1'b0;
    msg      <= ~m;
  endtask : send
endmodule : crf_rx_src
`default_nettype wire

// [verif/crf_rx_fifo_chk.sv]
// Concurrent checks on the ports of the receive-mode message FIFO.
`timescale 1ns/10ps
`default_nettype none
module crf_rx_fifo_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_stored,
  input wire logic       rx_lost,
  input wire logic       rx_valid,
  input wire logic       fifo_rx_irq,
  input wire logic       global_err_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only a register write may clear a flag or change an enable.
  wire wr_acc = psel && penable && pwrite;
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h38 |-> pslverr)
    else $error("no error on unmapped access");
  a_store_xor_lost: assert property (!(rx_stored && rx_lost))
    else $error("stored and lost together");
  a_pulse_cause: assert property (rx_stored || rx_lost |-> rx_valid)
    else $error("store pulse without offer");
  a_irq_source: assert property ($rose(fifo_rx_irq) |-> $past(rx_stored) || $past(wr_acc))
    else $error("rx irq without cause");
  a_irq_sticky: assert property (fifo_rx_irq && !wr_acc |=> fifo_rx_irq)
    else $error("rx irq dropped by itself");
  a_err_source: assert property ($rose(global_err_irq) |-> $past(rx_lost) || $past(wr_acc))
    else $error("error irq without loss");
  a_err_sticky: assert property (global_err_irq && !wr_acc |=> global_err_irq)
    else $error("error irq dropped by itself");
  c_lost: cover property (rx_lost);
  c_irq: cover property ($rose(fifo_rx_irq));
  c_store: cover property (rx_stored);
endmodule : crf_rx_fifo_chk
bind crf_rx_fifo crf_rx_fifo_chk crf_rx_fifo_chk_i (
  .pclk           (pclk),
  .presetn        (presetn),
  .psel           (psel),
  .penable        (penable),
  .pwrite         (pwrite),
  .paddr          (paddr),
  .pready         (pready),
  .pslverr        (pslverr),
  .rx_stored      (rx_stored),
  .rx_lost        (rx_lost),
  .rx_valid       (rx_valid),
  .fifo_rx_irq    (fifo_rx_irq),
  .global_err_irq (global_err_irq)
);
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the receive-mode message FIFO.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import crf_pkg::*;
  logic psel, penable, pwrite, pclk, presetn, rx_valid, pready, pslverr, irq, gerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, exp_q[$];
  logic [127:0] r;
  logic [3:0] rdlc;
  crf_entry_type m, x, sent[4];
  logic stored, lost;
  int n_fail, samples_checked, seed, n_st, n_lo;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  crf_rx_fifo crf_rx_fifo_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_identifier(m.id), .rx_ide(m.ide), .rx_rtr(m.rtr),
    .rx_dlc(m.dlc), .rule_dlc_value(rdlc), .rule_label_value(m.label), .rx_timestamp(m.tstamp),
    .rx_data(m.data), .rx_stored(stored), .rx_lost(lost), .fifo_rx_irq(irq),
    .global_err_irq(gerr));
  crf_rx_src crf_rx_src_i (.pclk(pclk), .rx_valid(rx_valid), .msg(m), .rule_dlc(rdlc));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Read data is judged at the edge that ends the access phase.
  always @(posedge pclk) if (psel && penable && !pwrite && pready === 1'b1) chk("prdata", exp_q.pop_front(), prdata);
  // Store and loss pulses are tallied at the edge that takes them; an unknown counts as absent.
  always @(posedge pclk) begin
    if (stored === 1'b1) n_st++;
    if (lost === 1'b1) n_lo++;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] dw(crf_entry_type y, int k);
    logic [31:0] o;
    o = 32'h0;
    for (int b = 0; b < 2; b++) if (2*k+b < y.dlc || y.dlc >= 8) o[8*b+:8] = y.data[8*(2*k+b)+:8];
    return o;
  endfunction : dw
  task automatic msg_chk(input crf_entry_type y);
    rd(OFF_ID_LOW, {16'h0, y.ide ? y.id[15:0] : {5'h0, y.id[10:0]}});
    rd(OFF_ID_HIGH, {16'h0, y.ide, y.rtr, 1'b0, y.ide ? y.id[28:16] : 13'h0});
    rd(OFF_TSTAMP, {16'h0, y.tstamp});
    rd(OFF_DLC_LBL, {16'h0, y.dlc, y.label});
    for (int k = 0; k < 4; k++) rd(OFF_DATA0 + 8'(4*k), dw(y, k));
  endtask : msg_chk
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, n_fail, samples_checked} = '0;
    seed = 85245;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 32'h1);
    rd(8'h3c, 32'h0);
    apb(1'b1, OFF_GCFG_LOW, 32'h3);
    apb(1'b1, OFF_GLOBAL_CONTROL_REG, 32'h1);
    apb(1'b1, OFF_WIN_CTRL, 32'h1);
    apb(1'b1, OFF_CFG_LOW, 32'h6102);
    apb(1'b1, OFF_CFG_LOW, 32'h6103);
    // Five offers into four slots: the last one must be lost.
    for (int i = 0; i < 5; i++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      rv = $random(seed);
      x = r[126:0];
      x.ide = 1'b0;
      x.rtr = 1'b0;
      crf_rx_src_i.send(x, rv[3:0]);
      x.dlc = rv[3:0];
      if (i < 4) sent[i] = x;
    end
    apb(1'b1, OFF_PTR_CTRL, 32'hfe);
    rd(OFF_STATUS, 32'h040e);
    chk("irq outputs", 32'h3, {30'h0, irq, gerr});
    chk("stored count", 32'h4, n_st);
    chk("lost count", 32'h1, n_lo);
    for (int i = 0; i < 4; i++) begin
      msg_chk(sent[i]);
      apb(1'b1, OFF_PTR_CTRL, 32'hff);
    end
    rd(OFF_STATUS, 32'h000d);
    apb(1'b1, OFF_CFG_LOW, 32'h6106);
    rd(OFF_STATUS, 32'h000d);
    apb(1'b1, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_GCFG_LOW, 32'h1);
    apb(1'b1, OFF_WIN_CTRL, 32'h0);
    apb(1'b1, OFF_CFG_LOW, 32'h6107);
    // An extended remote frame exercises the upper identifier view.
    x.ide = 1'b1;
    x.rtr = 1'b1;
    crf_rx_src_i.send(x, ~x.dlc);
    rd(OFF_ID_LOW, 32'h0);
    rd(OFF_STATUS, 32'h0108);
    apb(1'b1, OFF_WIN_CTRL, 32'h1);
    msg_chk(x);
    // Outside receive mode the window shuts and offers are ignored.
    apb(1'b1, OFF_CFG_HIGH, 32'h1);
    crf_rx_src_i.send(x, x.dlc);
    rd(OFF_ID_LOW, 32'h0);
    rd(OFF_STATUS, 32'h0108);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
